// *** common/strobe_port_pkg.sv ***
/*
  Constants, field layout and mode encoding of the programmable strobe port.
  Assumes the core special function register bus addresses bytes by 8-bit address
  and bits by 8-bit bit address (byte address bits 7:3, bit index 2:0).
*/
package strobe_port_pkg;
  // ************************
  // sizes
  // ************************
  localparam int pins = 4;
  localparam int span_w = 2;

  // ************************
  // register addresses
  // ************************
  localparam logic [7:0] extra_irq_ctrl_addr = 8'hc0;
  localparam logic [7:0] strobe_cfg_a_addr = 8'hc1;
  localparam logic [7:0] strobe_cfg_b_addr = 8'hc2;
  localparam logic [7:0] strobe_port_addr = 8'hd8;
  localparam logic [7:0] base_low_addr [pins] = '{8'ha4, 8'h94, 8'hac, 8'hb4};
  localparam logic [7:0] base_high_addr [pins] = '{8'ha5, 8'h95, 8'had, 8'hb5};

  // ************************
  // extra_irq_ctrl fields
  // ************************
  localparam int third_trig_bit = 0;
  localparam int third_pend_bit = 1;
  localparam int third_en_bit = 2;
  localparam int fourth_trig_bit = 4;
  localparam int fourth_pend_bit = 5;
  localparam int fourth_en_bit = 6;

  // ************************
  // pins and reset values
  // ************************
  localparam int third_irq_pin = 3;
  localparam int fourth_irq_pin = 2;
  localparam logic [pins-1:0] port_reset = 4'hf;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [15:0] full_mask = 16'hffff;

  typedef enum logic [1:0] {
    mode_gpio = 2'h0,
    mode_rd = 2'h1,
    mode_wr = 2'h2,
    mode_rdwr = 2'h3
  } mode_e;
endpackage

// *** common/xbus_if.sv ***
/*
  External data bus view shared by the port top and its address decoders.
  Assumes rd_act and wr_act are active-high forms of the core's strobes.
*/
`timescale 1ns/100ps
interface xbus_if;
  logic [15:0] addr;
  logic rd_act;
  logic wr_act;
  modport src (output addr, output rd_act, output wr_act);
  modport dec (input addr, input rd_act, input wr_act);
endinterface

// *** rtl/pin_sync.sv ***
/*
  Three-stage synchroniser with agreement filter for asynchronous pin inputs.
  Assumes one clock; level only moves when stages two and three agree.
*/
`timescale 1ns/100ps
module pin_sync
  import strobe_port_pkg::*;
#(
  parameter int width = pins
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [width-1:0] raw,
  output logic [width-1:0] level
);
  typedef struct packed {
    logic [width-1:0] s1;
    logic [width-1:0] s2;
    logic [width-1:0] s3;
    logic [width-1:0] filt;
  } sync_s;

  sync_s s_ff;
  sync_s nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.s1 = raw;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    for (int i = 0; i < width; i++)
    begin
      if (s_ff.s2[i] == s_ff.s3[i])
      begin
        nxt_s.filt[i] = s_ff.s3[i];
      end
    end
  end

  // pulled-up pins idle high
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_ff <= '1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign level = s_ff.filt;

  // per bit: a pin whose stages agree may move while a neighbour is still settling
  filter_agree_a: assert property (@(posedge clk) disable iff (reset) // R13
    (s_ff.s2 != s_ff.s3)
    |=> ((s_ff.filt ^ $past(s_ff.filt)) & $past(s_ff.s2 ^ s_ff.s3)) == '0)
    else $error("filtered level moved while stages disagreed");
endmodule

// *** rtl/strobe_decode.sv ***
/*
  Address match and strobe selection for one port pin.
  Assumes the caller registers the hit before it reaches a pin.
*/
`timescale 1ns/100ps
module strobe_decode
  import strobe_port_pkg::*;
(
  xbus_if.dec bus,
  input wire logic [15:0] base,
  input wire mode_e mode,
  input wire logic [span_w-1:0] span,
  output logic hit
);
  logic [15:0] mask;
  logic match;

  always_comb
  begin
    // span widens the window by ignoring low address bits
    mask = full_mask << span; // R9
    match = (bus.addr & mask) == (base & mask); // R15
    unique case (mode) // R2
      mode_gpio: hit = 1'b0;
      mode_rd: hit = match && bus.rd_act; // R5
      mode_wr: hit = match && bus.wr_act; // R6
      mode_rdwr: hit = match && (bus.rd_act || bus.wr_act); // R7
    endcase
  end
endmodule

// *** rtl/strobe_port.sv ***
/*
  Four-pin programmable port: quasi-bidirectional pins, decoded chip-select
  strobes and two extra external interrupt inputs with their control register.
  Assumes the core's register bus and external data bus strobes run on clk.
*/
//
// Contract
// [R1] the port data register sits at d8 and each pin is configured on its own.
// [R2] each pin has four software-selected modes numbered zero to three.
// [R3] mode zero makes the pin quasi-bidirectional with a pull-up.
// [R4] in mode zero pin two feeds the fourth and pin three the third extra interrupt.
// [R5] mode one drives a read strobe in step with the bus read, inside the range only.
// [R6] mode two drives a write strobe in step with the bus write, inside the range only.
// [R7] mode three drives a strobe on either read or write, inside the range only.
// [R8] each pin holds a 16-bit base address split over a high and a low byte.
// [R9] modes and the address range come from configuration registers a and b.
// [R10] outside chips use the strobes as chip selects for their own range.
// [R11] the extra interrupt control register sits at c0 and is bit-addressable.
// [R12] a bit set at bit address c2 enables the third extra interrupt.
// [R13] each extra interrupt takes a falling edge when its type bit is set, else a low level.
// [R14] in edge mode the pending flag is set by hardware and cleared on service.
// [R15] a strobe is active on an address equal to the base and stays high otherwise; the code also hits where only the low span bits differ.
// [R16] after reset all pins are mode zero with latch high and no strobe active.
`timescale 1ns/100ps
module strobe_port
  import strobe_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_val,
  input wire logic [15:0] xaddr,
  input wire logic xrd_n,
  input wire logic xwr_n,
  input wire logic [pins-1:0] pin_in,
  output logic [pins-1:0] pin_out,
  output logic [pins-1:0] pin_oe,
  input wire logic third_irq_ack,
  input wire logic fourth_irq_ack,
  output logic third_irq_req,
  output logic fourth_irq_req
);
  // ************************
  // state
  // ************************
  typedef struct packed {
    logic [pins-1:0] latch;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] ctrl;
    logic [pins-1:0][15:0] base;
    logic [pins-1:0] out;
    logic [pins-1:0] oe;
    logic [7:0] rdata;
    logic third_req;
    logic fourth_req;
    logic [pins-1:0] prev;
  } state_s;

  state_s s_ff;
  state_s nxt_s;
  logic [pins-1:0] lvl;
  logic [pins-1:0] hit;
  logic [pins-1:0] fall;
  xbus_if bus ();

  function automatic mode_e pin_mode(input logic [7:0] cfg, input int i);
    return mode_e'(cfg[2*i +: 2]);
  endfunction

  function automatic logic [span_w-1:0] pin_span(input logic [7:0] cfg, input int i);
    return cfg[2*i +: 2];
  endfunction

  // ************************
  // inputs and decoders
  // ************************
  pin_sync #(.width(pins)) u_sync (
    .clk(clk),
    .reset(reset),
    .raw(pin_in),
    .level(lvl)
  );

  assign bus.addr = xaddr;
  assign bus.rd_act = !xrd_n;
  assign bus.wr_act = !xwr_n;

  for (genvar g = 0; g < pins; g++)
  begin : g_dec
    strobe_decode u_dec (
      .bus(bus),
      .base(s_ff.base[g]),
      .mode(pin_mode(s_ff.cfg_a, g)),
      .span(pin_span(s_ff.cfg_b, g)),
      .hit(hit[g])
    );
  end

  assign fall = s_ff.prev & ~lvl;

  // ************************
  // next state
  // ************************
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.prev = lvl;
    if (sfr_wr)
    begin
      if (sfr_addr == strobe_port_addr)
      begin
        nxt_s.latch = sfr_wdata[pins-1:0]; // R1
      end
      if (sfr_addr == strobe_cfg_a_addr)
      begin
        nxt_s.cfg_a = sfr_wdata; // R9
      end
      if (sfr_addr == strobe_cfg_b_addr)
      begin
        nxt_s.cfg_b = sfr_wdata; // R9
      end
      if (sfr_addr == extra_irq_ctrl_addr)
      begin
        nxt_s.ctrl = sfr_wdata;
      end
      for (int i = 0; i < pins; i++)
      begin
        if (sfr_addr == base_low_addr[i])
        begin
          nxt_s.base[i][7:0] = sfr_wdata; // R8
        end
        if (sfr_addr == base_high_addr[i])
        begin
          nxt_s.base[i][15:8] = sfr_wdata; // R8
        end
      end
    end
    if (bit_wr)
    begin
      if (bit_addr[7:3] == strobe_port_addr[7:3] && !bit_addr[2])
      begin
        nxt_s.latch[bit_addr[1:0]] = bit_val;
      end
      if (bit_addr[7:3] == extra_irq_ctrl_addr[7:3])
      begin
        nxt_s.ctrl[bit_addr[2:0]] = bit_val; // R11 R12
      end
    end

    // hardware flags last so a detected edge beats a clear in the same cycle
    if (s_ff.ctrl[third_trig_bit])
    begin
      if (third_irq_ack)
      begin
        nxt_s.ctrl[third_pend_bit] = 1'b0; // R14
      end
      if (fall[third_irq_pin] && pin_mode(s_ff.cfg_a, third_irq_pin) == mode_gpio)
      begin
        nxt_s.ctrl[third_pend_bit] = 1'b1; // R13 R14
      end
    end
    else
    begin
      nxt_s.ctrl[third_pend_bit] = !lvl[third_irq_pin]
        && pin_mode(s_ff.cfg_a, third_irq_pin) == mode_gpio; // R13
    end
    if (s_ff.ctrl[fourth_trig_bit])
    begin
      if (fourth_irq_ack)
      begin
        nxt_s.ctrl[fourth_pend_bit] = 1'b0; // R14
      end
      if (fall[fourth_irq_pin] && pin_mode(s_ff.cfg_a, fourth_irq_pin) == mode_gpio)
      begin
        nxt_s.ctrl[fourth_pend_bit] = 1'b1; // R13 R14
      end
    end
    else
    begin
      nxt_s.ctrl[fourth_pend_bit] = !lvl[fourth_irq_pin]
        && pin_mode(s_ff.cfg_a, fourth_irq_pin) == mode_gpio; // R13
    end

    // irq only while the pin is a plain pin
    nxt_s.third_req = s_ff.ctrl[third_en_bit] && s_ff.ctrl[third_pend_bit]
      && pin_mode(s_ff.cfg_a, third_irq_pin) == mode_gpio; // R4
    nxt_s.fourth_req = s_ff.ctrl[fourth_en_bit] && s_ff.ctrl[fourth_pend_bit]
      && pin_mode(s_ff.cfg_a, fourth_irq_pin) == mode_gpio; // R4

    for (int i = 0; i < pins; i++)
    begin
      if (pin_mode(nxt_s.cfg_a, i) == mode_gpio)
      begin
        // quasi pin: drive only a low, the pull-up gives the high
        nxt_s.out[i] = nxt_s.latch[i]; // R3
        nxt_s.oe[i] = !nxt_s.latch[i]; // R3
      end
      else
      begin
        // active-low chip select, one cycle behind the bus strobe
        nxt_s.out[i] = !hit[i]; // R5 R6 R7 R10 R15
        nxt_s.oe[i] = 1'b1;
      end
    end

    nxt_s.rdata = reg_reset;
    if (sfr_addr == strobe_port_addr)
    begin
      nxt_s.rdata[pins-1:0] = lvl;
    end
    if (sfr_addr == strobe_cfg_a_addr)
    begin
      nxt_s.rdata = s_ff.cfg_a;
    end
    if (sfr_addr == strobe_cfg_b_addr)
    begin
      nxt_s.rdata = s_ff.cfg_b;
    end
    if (sfr_addr == extra_irq_ctrl_addr)
    begin
      nxt_s.rdata = s_ff.ctrl;
    end
    for (int i = 0; i < pins; i++)
    begin
      if (sfr_addr == base_low_addr[i])
      begin
        nxt_s.rdata = s_ff.base[i][7:0];
      end
      if (sfr_addr == base_high_addr[i])
      begin
        nxt_s.rdata = s_ff.base[i][15:8];
      end
    end
  end

  // ************************
  // registers
  // ************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_ff <= '0;
      s_ff.latch <= port_reset; // R16
      s_ff.out <= port_reset; // R16
      s_ff.prev <= port_reset;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign sfr_rdata = s_ff.rdata;
  assign pin_out = s_ff.out;
  assign pin_oe = s_ff.oe;
  assign third_irq_req = s_ff.third_req;
  assign fourth_irq_req = s_ff.fourth_req;

  // ************************
  // checks
  // ************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  reset_idle_a: assert property ($past(reset) |-> pin_out == port_reset && pin_oe == '0) // R16
    else $error("port not idle after reset");
  latch_write_a: assert property (sfr_wr && sfr_addr == strobe_port_addr && !bit_wr // R1
    |=> s_ff.latch == $past(sfr_wdata[pins-1:0]))
    else $error("port latch write lost");
  rd_strobe_a: assert property (pin_mode(s_ff.cfg_a, 0) == mode_rd && !xrd_n // R5
    && xaddr == s_ff.base[0] && !(sfr_wr || bit_wr)
    |=> !pin_out[0] && pin_oe[0])
    else $error("read strobe missing");
  wr_strobe_a: assert property (pin_mode(s_ff.cfg_a, 1) == mode_wr && !xwr_n // R6
    && xaddr == s_ff.base[1] && !(sfr_wr || bit_wr)
    |=> !pin_out[1] && pin_oe[1])
    else $error("write strobe missing");
  either_strobe_a: assert property (pin_mode(s_ff.cfg_a, 2) == mode_rdwr // R7
    && (!xwr_n || !xrd_n) && xaddr == s_ff.base[2] && !(sfr_wr || bit_wr)
    |=> !pin_out[2])
    else $error("read or write strobe missing");
  miss_high_a: assert property (pin_mode(s_ff.cfg_a, 0) != mode_gpio // R15
    && pin_span(s_ff.cfg_b, 0) == '0 && xaddr != s_ff.base[0] && !(sfr_wr || bit_wr)
    |=> pin_out[0])
    else $error("strobe active outside range");
  // checked against the latch, not against the other output
  quasi_drive_a: assert property (pin_mode(s_ff.cfg_a, 3) == mode_gpio // R3
    && !(sfr_wr || bit_wr)
    |=> pin_out[3] == s_ff.latch[3] && pin_oe[3] == !s_ff.latch[3])
    else $error("quasi pin drove a high");
  third_enable_a: assert property (bit_wr && bit_val // R12
    && bit_addr == {extra_irq_ctrl_addr[7:3], 3'(third_en_bit)} && !sfr_wr
    |=> s_ff.ctrl[third_en_bit])
    else $error("bit set did not enable third irq");
  edge_pend_a: assert property (s_ff.ctrl[third_trig_bit] && fall[third_irq_pin] // R14
    && pin_mode(s_ff.cfg_a, third_irq_pin) == mode_gpio
    |=> s_ff.ctrl[third_pend_bit])
    else $error("falling edge not latched");
  level_pend_a: assert property (!s_ff.ctrl[fourth_trig_bit] && !lvl[fourth_irq_pin] // R13
    && pin_mode(s_ff.cfg_a, fourth_irq_pin) == mode_gpio && !sfr_wr && !bit_wr
    |=> s_ff.ctrl[fourth_pend_bit])
    else $error("low level not pending");
  irq_req_a: assert property (third_irq_req |-> // R4
    $past(s_ff.ctrl[third_en_bit]) && $past(s_ff.ctrl[third_pend_bit]))
    else $error("irq request without enable and pending");

  rd_strobe_c: cover property (!pin_out[0] && pin_oe[0] ##1 pin_out[0]);
  edge_irq_c: cover property (fall[third_irq_pin] ##[1:4] third_irq_req);
  bit_set_c: cover property (bit_wr && bit_addr[7:3] == extra_irq_ctrl_addr[7:3]);
endmodule

// *** bench/periph_model.sv ***
/*
  Peripheral chips hanging on the strobe pins, plus the pad pull-ups.
  Assumes pin_oe high means the port drives the pad.
*/
`timescale 1ns/100ps
module periph_model
(
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pull_low,
  output logic [3:0] pad,
  output logic [3:0] sel
);
  // pull-up wins unless the port or a chip pulls low
  assign pad = ~((pin_oe & ~pin_out) | pull_low);
  // a chip is selected only while its strobe is driven low
  assign sel = pin_oe & ~pin_out;
endmodule

// *** bench/programmable_strobe_port_tb_top.sv ***
/*
  Self-checking bench for the programmable strobe port.
  Assumes periph_model supplies pad levels and chip selects.
*/
`timescale 1ns/100ps
module programmable_strobe_port_tb_top
  import strobe_port_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic bit_wr = 1'b0;
  logic [7:0] bit_addr = 8'h00;
  logic bit_val = 1'b0;
  logic [15:0] xaddr = 16'h0000;
  logic xrd_n = 1'b1;
  logic xwr_n = 1'b1;
  logic [3:0] pad, pin_out, pin_oe, sel;
  logic [3:0] pull_low = 4'h0;
  logic third_irq_ack = 1'b0;
  logic fourth_irq_ack = 1'b0;
  logic third_irq_req, fourth_irq_req;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  strobe_port uut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .bit_addr(bit_addr),
    .bit_val(bit_val), .xaddr(xaddr), .xrd_n(xrd_n), .xwr_n(xwr_n), .pin_in(pad),
    .pin_out(pin_out), .pin_oe(pin_oe), .third_irq_ack(third_irq_ack),
    .fourth_irq_ack(fourth_irq_ack), .third_irq_req(third_irq_req),
    .fourth_irq_req(fourth_irq_req));
  periph_model chips (.pin_out(pin_out), .pin_oe(pin_oe), .pull_low(pull_low), .pad(pad),
    .sel(sel));

  always #2 clk = ~clk;

  // ************************
  // shared tasks
  // ************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // tests take well under 1000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      $display("BAD t=%0t run hung", $time);
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    chk(sfr_rdata, exp, what);
  endtask

  task automatic bset(input logic [7:0] a, input logic v);
    @(negedge clk);
    bit_addr = a;
    bit_val = v;
    bit_wr = 1'b1;
    @(negedge clk);
    bit_wr = 1'b0;
  endtask

  // strobe answers one cycle after the bus strobe, releases one after it ends
  task automatic acc(input logic [15:0] a, input logic r_n, input logic w_n,
    input logic [3:0] exp, input string what);
    @(negedge clk);
    xaddr = a;
    xrd_n = r_n;
    xwr_n = w_n;
    @(negedge clk);
    chk(pin_out, exp, what);
    chk(sel[0], !exp[0], what);
    xrd_n = 1'b1;
    xwr_n = 1'b1;
    @(negedge clk);
    chk(pin_out, 4'hf, what);
  endtask

  task automatic wait_req(input bit third, input logic want, input string what);
    int n;
    n = 0;
    while (((third ? third_irq_req : fourth_irq_req) !== want) && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    chk(third ? third_irq_req : fourth_irq_req, want, what);
  endtask

  // ************************
  // scenarios
  // ************************
  task automatic t_reset();
    @(negedge clk);
    chk(pin_out, 4'hf, "reset latch");
    chk(pin_oe, 4'h0, "reset oe");
    chk({third_irq_req, fourth_irq_req}, 2'h0, "reset irq");
    rd(8'hc0, 8'h00, "reset ctrl");
    rd(8'hc1, 8'h00, "reset cfg a");
    rd(8'hc2, 8'h00, "reset cfg b");
    rd(8'hd8, 8'h0f, "reset port");
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < pins; i++)
    begin
      wr(base_low_addr[i], 8'h10 + 8'(i));
      wr(base_high_addr[i], 8'h20 + 8'(i));
    end
    for (int i = 0; i < pins; i++)
    begin
      rd(base_low_addr[i], 8'h10 + 8'(i), "base low");
      rd(base_high_addr[i], 8'h20 + 8'(i), "base high");
    end
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00, "unmapped");
    $display("test regs done");
  endtask

  task automatic t_strobe();
    logic [3:0] er, ew;
    wr(8'ha5, 8'h12);
    wr(8'ha4, 8'h34);
    for (int m = 1; m < 4; m++)
    begin
      wr(8'hc1, 8'(m));
      er = m[0] ? 4'he : 4'hf;
      ew = m[1] ? 4'he : 4'hf;
      chk(pin_oe[0], 1'b1, "strobe oe");
      acc(16'h1234, 1'b0, 1'b1, er, "read hit");
      acc(16'h1234, 1'b1, 1'b0, ew, "write hit");
      acc(16'h1235, 1'b0, 1'b0, 4'hf, "miss");
    end
    acc(16'h1234, 1'b0, 1'b0, 4'he, "either hit");
    wr(8'hc2, 8'h01);
    acc(16'h1235, 1'b0, 1'b1, 4'he, "span hit");
    // pin 1 write only, pin 2 either, bases left by the register test
    wr(8'hc1, 8'h38);
    acc(16'h2111, 1'b1, 1'b0, 4'hd, "pin1 write");
    acc(16'h2111, 1'b0, 1'b1, 4'hf, "pin1 read");
    acc(16'h2212, 1'b0, 1'b1, 4'hb, "pin2 read");
    acc(16'h2212, 1'b1, 1'b0, 4'hb, "pin2 write");
    wr(8'hc2, 8'h00);
    wr(8'hc1, 8'h00);
    acc(16'h1234, 1'b0, 1'b0, 4'hf, "mode zero");
    $display("test strobe done");
  endtask

  task automatic t_port();
    wr(8'hd8, 8'h0d);
    chk(pin_oe, 4'h2, "drive low oe");
    chk(pad[1], 1'b0, "pad low");
    pull_low = 4'h1;
    repeat (5) @(negedge clk);
    rd(8'hd8, 8'h0c, "pin read");
    pull_low = 4'h0;
    wr(8'hd8, 8'h0f);
    chk(pin_oe, 4'h0, "released");
    bset(8'hd8, 1'b0);
    chk(pin_oe, 4'h1, "bit clear drives");
    bset(8'hd8, 1'b1);
    chk(pin_oe, 4'h0, "bit set releases");
    $display("test port done");
  endtask

  task automatic t_irq();
    bset(8'hc2, 1'b1);
    bset(8'hc0, 1'b1);
    rd(8'hc0, 8'h05, "bit sets");
    pull_low = 4'h8;
    wait_req(1'b1, 1'b1, "third edge");
    rd(8'hc0, 8'h07, "pending");
    @(negedge clk);
    third_irq_ack = 1'b1;
    @(negedge clk);
    third_irq_ack = 1'b0;
    repeat (2) @(negedge clk);
    chk(third_irq_req, 1'b0, "ack clears");
    rd(8'hc0, 8'h05, "pending gone");
    pull_low = 4'h0;
    bset(8'hc6, 1'b1);
    pull_low = 4'h4;
    wait_req(1'b0, 1'b1, "fourth level");
    chk(third_irq_req, 1'b0, "third idle");
    pull_low = 4'h0;
    wait_req(1'b0, 1'b0, "level ends");
    bset(8'hc4, 1'b1);
    pull_low = 4'h4;
    wait_req(1'b0, 1'b1, "fourth edge");
    @(negedge clk);
    fourth_irq_ack = 1'b1;
    @(negedge clk);
    fourth_irq_ack = 1'b0;
    repeat (2) @(negedge clk);
    chk(fourth_irq_req, 1'b0, "fourth ack clears");
    pull_low = 4'h0;
    $display("test irq done");
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_regs();
    t_strobe();
    t_port();
    t_irq();
    close_out();
  end
endmodule
